// *** src/dsn_pkg.sv ***
// Package for the drive speed normalizer: parameter numbers, register numbers,
// control word bit positions and timing counts.
// Assumes a single 200 MHz core clock shared by every user of this package.
package dsn_pkg;
    // Inverter register numbers.
    localparam logic [15:0] REG_MAX_FREQ     = 16'h0004;
    localparam logic [15:0] REG_FREQ_CMD     = 16'h0706;
    localparam logic [15:0] REG_OUT_FREQ     = 16'h080a;
    localparam logic [15:0] REG_FAULT_FIRST  = 16'h0811;
    // Parameter numbers served to the network side.
    localparam logic [15:0] PN_SETPOINT      = 16'h02c7;
    localparam logic [15:0] PN_ACTUAL        = 16'h02c8;
    localparam logic [15:0] PN_CTRL_WORD     = 16'h0341;
    localparam logic [15:0] PN_STAT_WORD     = 16'h0342;
    localparam logic [15:0] PN_TELEGRAM      = 16'h039a;
    localparam logic [15:0] PN_FAULT_COUNT   = 16'h03b0;
    localparam logic [15:0] PN_FAULT_NUM     = 16'h03b3;
    localparam logic [15:0] PN_PROFILE_ID    = 16'h03c5;
    // Fixed parameter values.
    localparam logic [15:0] TELEGRAM_VALUE   = 16'h0001;
    localparam logic [15:0] PROFILE_ID_VALUE = 16'h0304;
    localparam logic [15:0] NORM_FULL_SCALE  = 16'h4000;
    localparam int          NORM_SHIFT       = 14;
    // Control word bit positions.
    localparam int          CW_FAULT_ACK_BIT = 7;
    localparam int          CW_REMOTE_BIT    = 10;
    // Register port layout (own choice).
    localparam logic [3:0]  ADR_STATUS       = 4'h0;
    localparam logic [3:0]  ADR_MASK         = 4'h1;
    localparam logic [3:0]  ADR_MAX_FREQ     = 4'h2;
    localparam logic [3:0]  ADR_ACTUAL       = 4'h3;
    localparam logic [3:0]  ADR_FAULT_COUNT  = 4'h4;
    localparam int          IRQ_LINK_LOST    = 0;
    localparam int          IRQ_FAULT_ACK    = 1;
    localparam int          IRQ_NEW_FAULT    = 2;
    localparam int          IRQ_BITS         = 3;
    // Indicator blink: one blink each second, half on, half off.
    localparam int          CLK_HZ           = 200_000_000;
    localparam int          BLINK_PERIOD_MS  = 1000;
    localparam int          BLINK_HALF_CYC   = CLK_HZ / 1000 * BLINK_PERIOD_MS / 2;
endpackage

// *** src/dsn_fault_mem.sv ***
// Small memory holding the four fault history entries read from the inverter.
// Assumes one writer and one reader in the core clock domain; read data is registered.
module dsn_fault_mem (
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    // Write port.
    input  wire logic        i_we,
    input  wire logic [1:0]  i_waddr,
    input  wire logic [15:0] i_wdata,
    // Read port.
    input  wire logic [1:0]  i_raddr,
    output logic      [15:0] o_rdata
);
    logic [15:0] mem_r [4];

    // Storage and registered read; entries clear at boot so reads are defined.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < 4; i++) mem_r[i] <= 16'h0000;
            o_rdata <= 16'h0000;
        end else begin
            if (i_we) mem_r[i_waddr] <= i_wdata;
            o_rdata <= mem_r[i_raddr];
        end
    end
endmodule

// *** src/dsn_normalizer.sv ***
// Drive speed normalizer: scales network speed setpoints into inverter frequency
// commands and inverter output frequency back into normalized actual speed.
// Assumes an inverter register master outside that reads and writes the inverter
// by register number, and a network side presenting process data and parameter reads.
// Notes on behaviour
// - Each setpoint becomes setpoint times max frequency over 0x4000, written to register 1798.
// - Actual speed is register 2058 times 0x4000 over the max frequency.
// - The max frequency used by both scalings comes from inverter register 4.
// - The max frequency is fetched once after boot and never again until the next reset.
// - A normalized value of 0x4000 stands for 100 percent of max frequency both ways.
// - Normalized speeds are signed; positive is forward and negative is reverse.
// - Every served parameter is read-only and a parameter write changes nothing.
// - Parameters 711, 712, 833 and 834 return setpoint, actual speed, control and status word.
// - Parameter 922 reads as 1, standard telegram 1.
// - Parameter 965 reads as profile 3, version 4.
// - Parameter 947 serves fault entries from registers 2065 to 2068, with a fault counter.
// - On inverter link loss the status indicator blinks red once each second.
// - The inverter alarm is reset only on a rising edge of control word bit 7.
// - Setpoint and control word are taken only while control word bit 10 is set; the status word is taken every cycle.
//
// Our own choices: the address-and-strobe port and the address map.
module dsn_normalizer (
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    // Network process data.
    input  wire logic        i_pd_valid,
    input  wire logic [15:0] i_speed_setpoint_norm,
    input  wire logic [15:0] i_drive_control_word,
    input  wire logic [15:0] i_drive_status_word,
    // Network parameter access.
    input  wire logic        i_par_rd,
    input  wire logic        i_par_wr,
    input  wire logic [15:0] i_parameter_number,
    input  wire logic [1:0]  i_par_index,
    output logic             o_par_ack,
    output logic             o_par_err,
    output logic      [15:0] o_par_data,
    // Inverter register master.
    output logic             o_inv_rd,
    output logic             o_inv_wr,
    output logic      [15:0] o_inv_addr,
    output logic      [15:0] o_inv_wdata,
    input  wire logic        i_inv_done,
    input  wire logic [15:0] i_inv_rdata,
    input  wire logic        i_inv_link_ok,
    // Alarm reset and indicator.
    output logic             o_alarm_reset,
    output logic             o_status_led_red,
    // Software register port.
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic [15:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [15:0] o_reg_rdata,
    output logic             o_irq
);
    typedef enum logic [2:0] {
        DSN_BOOT_RD, DSN_BOOT_WT, DSN_IDLE, DSN_CMD_WT, DSN_ACT_WT, DSN_FLT_WT
    } dsn_state_t;

    // Signed 16-bit saturation of a 48-bit signed quotient.
    function automatic logic [15:0] dsn_sat16(input logic signed [47:0] v);
        if (v > 48'sd32767) return 16'h7fff;
        else if (v < -48'sd32768) return 16'h8000;
        else return v[15:0];
    endfunction

    dsn_state_t           state_r, state_nxt;
    logic [15:0]          max_freq_r;
    logic [15:0]          setpoint_r;
    logic [15:0]          actual_r;
    logic [15:0]          ctrl_word_r;
    logic [15:0]          stat_word_r;
    logic                 ack_bit_prev_r;
    logic                 cmd_pend_r;
    logic [1:0]           flt_idx_r;
    logic [15:0]          fault_count_r;
    logic [15:0]          last_fault_r;
    logic [31:0]          blink_cnt_r;
    logic                 blink_r;
    logic [2:0]           irq_stat_r;
    logic [2:0]           irq_mask_r;
    logic                 link_ok_prev_r;
    logic [15:0]          flt_rdata;
    logic                 par_rd_d_r;
    logic [15:0]          par_num_d_r;
    logic                 par_wr_d_r;

    // Scaling datapath: signed products, division truncates toward zero.
    wire logic signed [47:0] sp_prod   = 48'(signed'(setpoint_r)) * 48'(signed'({1'b0, max_freq_r}));
    wire logic signed [47:0] cmd_quot  = sp_prod / 48'sd16384;
    wire logic signed [47:0] act_prod  = 48'(signed'(i_inv_rdata)) * 48'sd16384;
    wire logic signed [47:0] max_div   = (max_freq_r == 16'h0000) ? 48'sd1 :
                                         48'(signed'({1'b0, max_freq_r}));
    wire logic signed [47:0] act_quot  = act_prod / max_div;
    wire logic [15:0]        cmd_value = dsn_sat16(cmd_quot);
    wire logic [15:0]        act_value = dsn_sat16(act_quot);
    wire logic               pd_take   = i_pd_valid && i_drive_control_word[dsn_pkg::CW_REMOTE_BIT];
    wire logic               ack_rise  = ctrl_word_r[dsn_pkg::CW_FAULT_ACK_BIT] && !ack_bit_prev_r;
    wire logic               link_lost_ev = link_ok_prev_r && !i_inv_link_ok;
    wire logic               flt_done  = (state_r == DSN_FLT_WT) && i_inv_done;
    wire logic               new_fault = flt_done && (flt_idx_r == 2'd0) &&
                                         (i_inv_rdata != 16'h0000) && (i_inv_rdata != last_fault_r);
    wire logic [2:0]         irq_ev    = {new_fault, ack_rise, link_lost_ev};
    wire logic               rd_status = i_reg_rd && (i_reg_addr == dsn_pkg::ADR_STATUS);

    // Inverter access sequencer: one boot read, then command, actual and fault polls.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            DSN_BOOT_RD: state_nxt = DSN_BOOT_WT;
            DSN_BOOT_WT: if (i_inv_done) state_nxt = DSN_IDLE;
            DSN_IDLE:    state_nxt = cmd_pend_r ? DSN_CMD_WT : DSN_ACT_WT;
            DSN_CMD_WT:  if (i_inv_done) state_nxt = DSN_ACT_WT;
            DSN_ACT_WT:  if (i_inv_done) state_nxt = DSN_FLT_WT;
            DSN_FLT_WT:  if (i_inv_done) state_nxt = DSN_IDLE;
            default:     state_nxt = DSN_IDLE;
        endcase
    end

    // Request issue: a single-cycle strobe on entry to each wait state.
    wire logic start_cmd = (state_r == DSN_IDLE) && cmd_pend_r;
    wire logic start_act = ((state_r == DSN_IDLE) && !cmd_pend_r) ||
                           ((state_r == DSN_CMD_WT) && i_inv_done);
    wire logic start_flt = (state_r == DSN_ACT_WT) && i_inv_done;
    wire logic start_max = (state_r == DSN_BOOT_RD);

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r     <= DSN_BOOT_RD;
            o_inv_rd    <= 1'b0;
            o_inv_wr    <= 1'b0;
            o_inv_addr  <= 16'h0000;
            o_inv_wdata <= 16'h0000;
        end else begin
            state_r  <= state_nxt;
            o_inv_rd <= start_max || start_act || start_flt;
            o_inv_wr <= start_cmd;
            if (start_max) o_inv_addr <= dsn_pkg::REG_MAX_FREQ;
            else if (start_cmd) o_inv_addr <= dsn_pkg::REG_FREQ_CMD;
            else if (start_act) o_inv_addr <= dsn_pkg::REG_OUT_FREQ;
            else if (start_flt) o_inv_addr <= dsn_pkg::REG_FAULT_FIRST + {14'h0000, flt_idx_r};
            if (start_cmd) o_inv_wdata <= cmd_value;
        end
    end

    // Max frequency is captured only from the boot read; nothing else writes it.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) max_freq_r <= 16'h0000;
        else if ((state_r == DSN_BOOT_WT) && i_inv_done) max_freq_r <= i_inv_rdata;
    end

    // Process data latch; setpoint and control word ignored unless remote control is enabled.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            setpoint_r  <= 16'h0000;
            ctrl_word_r <= 16'h0000;
            stat_word_r <= 16'h0000;
            cmd_pend_r  <= 1'b0;
        end else begin
            stat_word_r <= i_drive_status_word;
            if (pd_take) begin
                setpoint_r  <= i_speed_setpoint_norm;
                ctrl_word_r <= i_drive_control_word;
            end
            if (pd_take) cmd_pend_r <= 1'b1;
            else if (start_cmd) cmd_pend_r <= 1'b0;
        end
    end

    // Actual speed and fault history update from inverter reads.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            actual_r      <= 16'h0000;
            flt_idx_r     <= 2'd0;
            fault_count_r <= 16'h0000;
            last_fault_r  <= 16'h0000;
        end else begin
            if ((state_r == DSN_ACT_WT) && i_inv_done) actual_r <= act_value;
            if (flt_done) flt_idx_r <= flt_idx_r + 2'd1;
            if (new_fault) begin
                fault_count_r <= fault_count_r + 16'h0001;
                last_fault_r  <= i_inv_rdata;
            end
        end
    end

    dsn_fault_mem u_fault_mem (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_we       (flt_done),
        .i_waddr    (flt_idx_r),
        .i_wdata    (i_inv_rdata),
        .i_raddr    (i_par_index),
        .o_rdata    (flt_rdata)
    );

    // Alarm reset fires only on a rising edge of the acknowledge bit.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_bit_prev_r <= 1'b0;
            o_alarm_reset  <= 1'b0;
        end else begin
            ack_bit_prev_r <= ctrl_word_r[dsn_pkg::CW_FAULT_ACK_BIT];
            o_alarm_reset  <= ack_rise;
        end
    end

    // Parameter service: reads answered two cycles later, a write is refused.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            par_rd_d_r  <= 1'b0;
            par_wr_d_r  <= 1'b0;
            par_num_d_r <= 16'h0000;
        end else begin
            par_rd_d_r  <= i_par_rd;
            par_wr_d_r  <= i_par_wr && !i_par_rd;
            par_num_d_r <= i_parameter_number;
        end
    end

    // The fault memory read takes a cycle, so its data lines up with the request delayed by one cycle.
    wire logic [15:0] par_value =
        (par_num_d_r == dsn_pkg::PN_SETPOINT)    ? setpoint_r :
        (par_num_d_r == dsn_pkg::PN_ACTUAL)      ? actual_r :
        (par_num_d_r == dsn_pkg::PN_CTRL_WORD)   ? ctrl_word_r :
        (par_num_d_r == dsn_pkg::PN_STAT_WORD)   ? stat_word_r :
        (par_num_d_r == dsn_pkg::PN_TELEGRAM)    ? dsn_pkg::TELEGRAM_VALUE :
        (par_num_d_r == dsn_pkg::PN_PROFILE_ID)  ? dsn_pkg::PROFILE_ID_VALUE :
        (par_num_d_r == dsn_pkg::PN_FAULT_NUM)   ? flt_rdata :
        (par_num_d_r == dsn_pkg::PN_FAULT_COUNT) ? fault_count_r : 16'h0000;
    wire logic par_known =
        (par_num_d_r == dsn_pkg::PN_SETPOINT)   || (par_num_d_r == dsn_pkg::PN_ACTUAL) ||
        (par_num_d_r == dsn_pkg::PN_CTRL_WORD)  || (par_num_d_r == dsn_pkg::PN_STAT_WORD) ||
        (par_num_d_r == dsn_pkg::PN_TELEGRAM)   || (par_num_d_r == dsn_pkg::PN_PROFILE_ID) ||
        (par_num_d_r == dsn_pkg::PN_FAULT_NUM)  || (par_num_d_r == dsn_pkg::PN_FAULT_COUNT);

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_par_ack  <= 1'b0;
            o_par_err  <= 1'b0;
            o_par_data <= 16'h0000;
        end else begin
            o_par_ack  <= par_rd_d_r || par_wr_d_r;
            o_par_err  <= par_wr_d_r || (par_rd_d_r && !par_known);
            o_par_data <= par_rd_d_r ? par_value : 16'h0000;
        end
    end

    // Link-loss blink: one second period from a counter that runs only while the link is lost.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            blink_cnt_r      <= 32'h0000_0000;
            blink_r          <= 1'b0;
            o_status_led_red <= 1'b0;
            link_ok_prev_r   <= 1'b1;
        end else begin
            link_ok_prev_r <= i_inv_link_ok;
            if (i_inv_link_ok) begin
                blink_cnt_r <= 32'h0000_0000;
                blink_r     <= 1'b0;
            end else if (blink_cnt_r == 32'(dsn_pkg::BLINK_HALF_CYC - 1)) begin
                blink_cnt_r <= 32'h0000_0000;
                blink_r     <= !blink_r;
            end else begin
                blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
            end
            o_status_led_red <= !i_inv_link_ok && !blink_r;
        end
    end

    // Sticky events: a new event in the clearing read cycle survives the clear.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_stat_r  <= 3'h0;
            irq_mask_r  <= 3'h0;
            o_irq       <= 1'b0;
            o_reg_rdata <= 16'h0000;
        end else begin
            irq_stat_r <= (rd_status ? 3'h0 : irq_stat_r) | irq_ev;
            if (i_reg_wr && (i_reg_addr == dsn_pkg::ADR_MASK)) irq_mask_r <= i_reg_wdata[2:0];
            o_irq <= |(((rd_status ? 3'h0 : irq_stat_r) | irq_ev) & irq_mask_r);
            if (i_reg_rd) begin
                unique case (i_reg_addr)
                    dsn_pkg::ADR_STATUS:      o_reg_rdata <= {13'h0000, irq_stat_r};
                    dsn_pkg::ADR_MASK:        o_reg_rdata <= {13'h0000, irq_mask_r};
                    dsn_pkg::ADR_MAX_FREQ:    o_reg_rdata <= max_freq_r;
                    dsn_pkg::ADR_ACTUAL:      o_reg_rdata <= actual_r;
                    dsn_pkg::ADR_FAULT_COUNT: o_reg_rdata <= fault_count_r;
                    default:                  o_reg_rdata <= 16'h0000;
                endcase
            end else begin
                o_reg_rdata <= 16'h0000;
            end
        end
    end

    // Checks on the datapath and control.
    property p_boot_once;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (state_r != DSN_BOOT_WT) |=> $stable(max_freq_r);
    endproperty
    a_boot_once: assert property (p_boot_once) else $error("max frequency changed after boot");
    property p_cmd_addr;
        @(posedge i_core_clk) disable iff (!i_resetn)
        start_cmd |=> (o_inv_wr && o_inv_addr == dsn_pkg::REG_FREQ_CMD &&
                       o_inv_wdata == $past(cmd_value));
    endproperty
    a_cmd_addr: assert property (p_cmd_addr) else $error("frequency command not issued");
    property p_max_addr;
        @(posedge i_core_clk) disable iff (!i_resetn)
        start_max |=> (o_inv_rd && o_inv_addr == dsn_pkg::REG_MAX_FREQ);
    endproperty
    a_max_addr: assert property (p_max_addr) else $error("boot read address wrong");
    property p_act;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (state_r == DSN_ACT_WT && i_inv_done) |=> actual_r == $past(act_value);
    endproperty
    a_act: assert property (p_act) else $error("actual speed not updated");
    property p_remote;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_pd_valid && !i_drive_control_word[dsn_pkg::CW_REMOTE_BIT]) |=> $stable(setpoint_r);
    endproperty
    a_remote: assert property (p_remote) else $error("data taken without remote");
    property p_ack_edge;
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_alarm_reset |-> ($past(ctrl_word_r[dsn_pkg::CW_FAULT_ACK_BIT]) &&
                           !$past(ack_bit_prev_r));
    endproperty
    a_ack_edge: assert property (p_ack_edge) else $error("alarm reset without edge");
    property p_par_wr;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_par_wr && !i_par_rd) |=> ##1 (o_par_ack && o_par_err);
    endproperty
    a_par_wr: assert property (p_par_wr) else $error("parameter write accepted");
    property p_telegram;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_par_rd && i_parameter_number == dsn_pkg::PN_TELEGRAM) |=>
            ##1 (o_par_data == dsn_pkg::TELEGRAM_VALUE);
    endproperty
    a_telegram: assert property (p_telegram) else $error("telegram value wrong");
    property p_profile;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_par_rd && i_parameter_number == dsn_pkg::PN_PROFILE_ID) |=>
            ##1 (o_par_data == dsn_pkg::PROFILE_ID_VALUE);
    endproperty
    a_profile: assert property (p_profile) else $error("profile id wrong");
    property p_led_off;
        @(posedge i_core_clk) disable iff (!i_resetn)
        i_inv_link_ok |=> !o_status_led_red;
    endproperty
    a_led_off: assert property (p_led_off) else $error("indicator lit with link up");
    c_cmd:   cover property (@(posedge i_core_clk) disable iff (!i_resetn) start_cmd);
    c_ack:   cover property (@(posedge i_core_clk) disable iff (!i_resetn) o_alarm_reset);
    c_fault: cover property (@(posedge i_core_clk) disable iff (!i_resetn) new_fault);
endmodule

// *** sim/dsn_inv_model.sv ***
// Behavioural inverter register set answering the normalizer's register master.
// Assumes one-cycle strobes on the core clock; done comes three cycles later.
module dsn_inv_model (
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    // Register access from the block.
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    // Register contents set by the bench.
    input  wire logic [15:0] i_max_freq,
    input  wire logic [15:0] i_out_freq,
    // Answer and last frequency command.
    output logic             o_done,
    output logic      [15:0] o_rdata,
    output logic      [15:0] o_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  wait_r;
    logic [15:0] addr_r;
    // The data bus toggles outside answers so a stale value is never mistaken for one.
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wait_r <= 2'h0;
            o_done <= 1'b0;
            o_rdata <= 16'h0;
            o_cmd <= 16'h0;
        end else begin
            o_done <= 1'b0;
            o_rdata <= ~o_rdata;
            if (i_rd || i_wr) begin
                wait_r <= 2'h2;
                addr_r <= i_addr;
                if (i_wr && i_addr == dsn_pkg::REG_FREQ_CMD) o_cmd <= i_wdata;
            end else if (wait_r != 2'h0) begin
                wait_r <= wait_r - 2'h1;
                o_done <= (wait_r == 2'h1);
                if (wait_r == 2'h1) o_rdata <= (addr_r == dsn_pkg::REG_MAX_FREQ) ? i_max_freq :
                    (addr_r == dsn_pkg::REG_OUT_FREQ) ? i_out_freq : 16'h0;
            end
        end
    end
endmodule

// *** sim/tb_dsn_normalizer.sv ***
// Self-checking bench for the drive speed normalizer.
// Assumes the inverter model answers every access; the fault index stays 0.
module tb_dsn_normalizer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, pdv = 0, prd = 0, pwr = 0, rwr = 0, rrd = 0, link = 1;
    logic [15:0] sp = 0, cw = 0, sw = 16'h0237, pnum = 0, rwd = 0, maxf = 16'h1000;
    logic [15:0] outf = 16'h0800, pdat, iadr, iwd, idat, rdat, cmd;
    logic [3:0]  radr = 0;
    logic        ack, err, ird, iwr, done, alm, led, irq;
    int          mismatches = 0, samples_checked = 0, alm_n = 0, k;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (alm === 1'b1) alm_n++;
    dsn_normalizer i_dsn_normalizer (.i_core_clk(clk), .i_resetn(rstn), .i_pd_valid(pdv),
        .i_speed_setpoint_norm(sp), .i_drive_control_word(cw), .i_drive_status_word(sw),
        .i_par_rd(prd), .i_par_wr(pwr), .i_parameter_number(pnum), .i_par_index(2'h0),
        .o_par_ack(ack), .o_par_err(err), .o_par_data(pdat), .o_inv_rd(ird), .o_inv_wr(iwr),
        .o_inv_addr(iadr), .o_inv_wdata(iwd), .i_inv_done(done), .i_inv_rdata(idat),
        .i_inv_link_ok(link), .o_alarm_reset(alm), .o_status_led_red(led), .i_reg_addr(radr),
        .i_reg_wdata(rwd), .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rdat), .o_irq(irq));
    dsn_inv_model i_dsn_inv_model (.i_core_clk(clk), .i_resetn(rstn), .i_rd(ird), .i_wr(iwr),
        .i_addr(iadr), .i_wdata(iwd), .i_max_freq(maxf), .i_out_freq(outf), .o_done(done),
        .o_rdata(idat), .o_cmd(cmd));
    // Compares and counts; case inequality keeps unknowns from passing.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic par(input logic w, input logic [15:0] n, input logic [15:0] e, input logic f);
        @(posedge clk);
        prd <= !w; pwr <= w; pnum <= n;
        @(posedge clk);
        prd <= 1'b0; pwr <= 1'b0;
        for (k = 0; k < 6 && ack !== 1'b1; k++) @(negedge clk);
        chk({15'h0, ack}, 16'h1);
        chk({15'h0, err}, {15'h0, f});
        if (!w) chk(pdat, e);
    endtask
    task automatic rw(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        rwr <= 1'b1; radr <= a; rwd <= d;
        @(posedge clk);
        rwr <= 1'b0;
    endtask
    task automatic rr(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        rrd <= 1'b1; radr <= a;
        @(posedge clk);
        rrd <= 1'b0;
        @(negedge clk);
        chk(rdat, e);
    endtask
    // Sends one process data word, then waits a fixed time that covers a full poll round,
    // so that an unchanged command really means the word was not acted on.
    task automatic pd(input logic [15:0] s, input logic [15:0] c, input logic [15:0] e);
        @(posedge clk);
        pdv <= 1'b1; sp <= s; cw <= c;
        @(posedge clk);
        pdv <= 1'b0;
        repeat (40) @(negedge clk);
        chk(cmd, e);
    endtask
    task automatic boot();
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (80) @(posedge clk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // A hang counts as a mismatch and ends the run.
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        end_sim();
    end
    initial begin
        boot();
        rr(dsn_pkg::ADR_MAX_FREQ, 16'h1000);
        par(1'b0, dsn_pkg::PN_ACTUAL, 16'h2000, 1'b0);
        rr(dsn_pkg::ADR_ACTUAL, 16'h2000);
        $display("test boot scaling done");
        pd(16'h4000, 16'h0400, 16'h1000);
        pd(16'he000, 16'h0400, 16'hf800);
        pd(16'hffff, 16'h0400, 16'h0000);
        pd(16'h1234, 16'h0000, 16'h0000);
        pd(16'hffff, 16'h0480, 16'h0000);
        pd(16'hffff, 16'h0480, 16'h0000);
        chk(16'(alm_n), 16'h1);
        $display("test setpoint done");
        par(1'b0, dsn_pkg::PN_TELEGRAM, 16'h0001, 1'b0);
        par(1'b0, dsn_pkg::PN_PROFILE_ID, 16'h0304, 1'b0);
        par(1'b0, dsn_pkg::PN_STAT_WORD, 16'h0237, 1'b0);
        par(1'b0, dsn_pkg::PN_CTRL_WORD, 16'h0480, 1'b0);
        par(1'b1, dsn_pkg::PN_SETPOINT, 16'h0, 1'b1);
        par(1'b0, dsn_pkg::PN_SETPOINT, 16'hffff, 1'b0);
        par(1'b0, dsn_pkg::PN_FAULT_NUM, 16'h0000, 1'b0);
        par(1'b0, dsn_pkg::PN_FAULT_COUNT, 16'h0000, 1'b0);
        $display("test parameters done");
        // A set mask bit lets its event through; only link loss is enabled here.
        rw(dsn_pkg::ADR_MASK, 16'h0001);
        @(posedge clk) link <= 1'b0;
        repeat (4) @(negedge clk);
        chk({15'h0, led}, 16'h1);
        chk({15'h0, irq}, 16'h1);
        rw(dsn_pkg::ADR_MASK, 16'h0000);
        repeat (2) @(negedge clk);
        chk({15'h0, irq}, 16'h0);
        @(posedge clk) link <= 1'b1;
        rr(dsn_pkg::ADR_STATUS, 16'h0003);
        rr(dsn_pkg::ADR_STATUS, 16'h0000);
        $display("test link loss done");
        @(posedge clk) outf <= 16'h2000;
        maxf <= 16'h2000;
        repeat (80) @(posedge clk);
        rr(dsn_pkg::ADR_ACTUAL, 16'h7fff);
        boot();
        rr(dsn_pkg::ADR_ACTUAL, 16'h4000);
        $display("test reboot done");
        end_sim();
    end
endmodule
